// *** hdl/pmc_avg.sv ***
`timescale 1ns/1ps
module pmc_avg
    import pmc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic clear,              // Drop a partial sum
    input wire logic sample_valid,       // One-cycle pulse per conversion
    input wire logic sample_last,        // Last sample of the set
    input wire logic signed [15:0] sample,
    input wire logic [3:0] shift,        // log2 of the sample count
    output logic [15:0] mean,
    output logic mean_valid
);

    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic signed [25:0] sum; // 16 bits plus ten for 1024 samples
        logic [15:0] mean;
        logic valid;
    } pmc_avg_s;

    pmc_avg_s avg_r;
    pmc_avg_s avg_nxt;

    //--------------------------------------------------------------------------
    // Next state: accumulate, then divide by shifting
    //--------------------------------------------------------------------------
    always_comb begin
        logic signed [25:0] total;
        total = avg_r.sum + 26'(sample);
        avg_nxt = avg_r;
        avg_nxt.valid = 1'b0;
        if (clear) begin
            // Config write discards a half-collected set
            avg_nxt.sum = '0;
        end else if (sample_valid) begin
            if (sample_last) begin
                // Arithmetic shift keeps the sign of shunt readings
                avg_nxt.mean = 16'(total >>> shift);
                avg_nxt.sum = '0;
                avg_nxt.valid = 1'b1;
            end else begin
                avg_nxt.sum = total;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Register
    //--------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            avg_r <= '0;
        end else if (clk_en) begin
            avg_r <= avg_nxt;
        end
    end

    assign mean = avg_r.mean;
    assign mean_valid = avg_r.valid;

endmodule : pmc_avg

// *** hdl/pmc_core.sv ***
`timescale 1ns/1ps
module pmc_core
    import pmc_pkg::*;
#(
    // Cycles per conversion time code; shorten for simulation
    parameter logic [17:0] CONV_CYC [0:7] = CONV_CYC_DEF
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [7:0] reg_ptr,          // Register pointer
    input wire logic reg_wr,                 // Write strobe
    input wire logic reg_rd,                 // Read strobe
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] shunt_drop_value, // Converter shunt code, signed
    input wire logic [14:0] supply_rail_value, // Converter bus code
    output logic adc_shunt_active,           // Shunt conversion running
    output logic adc_bus_active,             // Bus conversion running
    output logic set_done                    // Pulse when a set completes
);

    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cfg;         // Configuration register
        logic [15:0] shunt_res;   // Shunt result register
        logic [15:0] bus_res;     // Bus result register
        logic [15:0] rdata;       // Read data
        pmc_state_e st;           // Sequencer state
        logic [17:0] tmr;         // Conversion timer
        logic [10:0] rounds;      // Rounds taken in this set
        logic done;               // Set-complete pulse
    } pmc_core_s;

    pmc_core_s core_r;
    pmc_core_s core_nxt;

    //--------------------------------------------------------------------------
    // Decoded configuration
    //--------------------------------------------------------------------------
    logic [3:0] shift;            // Averaging shift
    logic [10:0] avg_cnt;         // Averaging sample count
    logic [17:0] shunt_cyc;       // Shunt conversion length
    logic [17:0] bus_cyc;         // Bus conversion length
    logic want_shunt;
    logic want_bus;
    logic cont_mode;
    logic last_round;
    logic cfg_wr;                 // Write to the configuration register
    logic soft_rst;               // Reset bit written as one
    logic shunt_smp;              // Shunt conversion ends
    logic bus_smp;                // Bus conversion ends
    logic [15:0] shunt_mean;
    logic shunt_mean_vld;
    logic [15:0] bus_mean;
    logic bus_mean_vld;

    assign shift = avg_shift(core_r.cfg[AVG_MSB:AVG_LSB]);
    assign avg_cnt = 11'h001 << shift;
    assign bus_cyc = CONV_CYC[core_r.cfg[BCT_MSB:BCT_LSB]];
    assign shunt_cyc = CONV_CYC[core_r.cfg[SCT_MSB:SCT_LSB]];
    assign want_shunt = core_r.cfg[MODE_SHUNT_BIT];
    assign want_bus = core_r.cfg[MODE_BUS_BIT];
    assign cont_mode = core_r.cfg[MODE_CONT_BIT];
    assign last_round = (core_r.rounds == avg_cnt - 11'h001);
    assign cfg_wr = reg_wr && (reg_ptr == PTR_CONFIG);
    assign soft_rst = cfg_wr && reg_wdata[CFG_RST_BIT];

    // Sample strobes come straight from the running timer
    assign shunt_smp = (core_r.st == ST_SHUNT) && (core_r.tmr == shunt_cyc - 18'h00001);
    assign bus_smp = (core_r.st == ST_BUS) && (core_r.tmr == bus_cyc - 18'h00001);

    //--------------------------------------------------------------------------
    // Averagers, one per channel
    //--------------------------------------------------------------------------
    pmc_avg u_shunt_avg (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .clear(cfg_wr),
        .sample_valid(shunt_smp),
        .sample_last(last_round),
        .sample(shunt_drop_value),
        .shift(shift),
        .mean(shunt_mean),
        .mean_valid(shunt_mean_vld)
    );

    // Bus code is unsigned, so it enters with a zero sign bit
    pmc_avg u_bus_avg (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .clear(cfg_wr),
        .sample_valid(bus_smp),
        .sample_last(last_round),
        .sample({1'b0, supply_rail_value}),
        .shift(shift),
        .mean(bus_mean),
        .mean_valid(bus_mean_vld)
    );

    //--------------------------------------------------------------------------
    // Next state: sequencer, result update, register access
    //--------------------------------------------------------------------------
    always_comb begin
        core_nxt = core_r;
        core_nxt.done = 1'b0;

        // Results take the newest completed mean
        if (shunt_mean_vld) begin
            core_nxt.shunt_res = shunt_mean;
        end
        if (bus_mean_vld) begin
            core_nxt.bus_res = {1'b0, bus_mean[14:0]};
        end

        // Sequencer
        case (core_r.st)
            ST_START: begin
                core_nxt.tmr = '0;
                if (!want_shunt && !want_bus) begin
                    // Power-down: nothing converts
                    core_nxt.st = ST_IDLE;
                end else if (want_shunt) begin
                    core_nxt.st = ST_SHUNT;
                end else begin
                    core_nxt.st = ST_BUS;
                end
            end
            ST_SHUNT: begin
                core_nxt.tmr = core_r.tmr + 18'h00001;
                if (shunt_smp) begin
                    core_nxt.tmr = '0;
                    if (want_bus) begin
                        core_nxt.st = ST_BUS;
                    end else begin
                        core_nxt.st = ST_START;
                    end
                end
            end
            ST_BUS: begin
                core_nxt.tmr = core_r.tmr + 18'h00001;
                if (bus_smp) begin
                    core_nxt.tmr = '0;
                    core_nxt.st = ST_START;
                end
            end
            ST_IDLE: begin
                // Wait for a configuration write
                core_nxt.tmr = '0;
            end
            default: begin
                core_nxt.st = ST_IDLE;
            end
        endcase

        // End of a round: count it, and close the set on the last one
        if ((shunt_smp && !want_bus) || bus_smp) begin
            if (last_round) begin
                core_nxt.rounds = '0;
                core_nxt.done = 1'b1;
                // Triggered mode stops after one set
                core_nxt.st = cont_mode ? ST_START : ST_IDLE;
            end else begin
                core_nxt.rounds = core_r.rounds + 11'h001;
            end
        end

        // Reads never disturb a conversion; unmapped pointers read zero
        if (reg_rd) begin
            case (reg_ptr)
                PTR_CONFIG: core_nxt.rdata = core_r.cfg;
                PTR_SHUNT: core_nxt.rdata = core_r.shunt_res;
                PTR_BUS: core_nxt.rdata = core_r.bus_res;
                default: core_nxt.rdata = 16'h0000;
            endcase
        end

        // Config write restarts the sequence with the new settings
        if (cfg_wr) begin
            core_nxt.cfg = {1'b0, CFG_RSVD_VAL, reg_wdata[AVG_MSB:0]};
            core_nxt.st = ST_START;
            core_nxt.tmr = '0;
            core_nxt.rounds = '0;
            core_nxt.done = 1'b0;
        end

        // Reset bit behaves like a power-on reset; the bit is never stored
        if (soft_rst) begin
            core_nxt.cfg = CFG_RESET_VAL;
            core_nxt.shunt_res = RESULT_RESET_VAL;
            core_nxt.bus_res = RESULT_RESET_VAL;
            core_nxt.rdata = 16'h0000;
        end
    end

    //--------------------------------------------------------------------------
    // Register; clock enable freezes everything
    //--------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            core_r.cfg <= CFG_RESET_VAL;
            core_r.shunt_res <= RESULT_RESET_VAL;
            core_r.bus_res <= RESULT_RESET_VAL;
            core_r.rdata <= 16'h0000;
            core_r.st <= ST_START;
            core_r.tmr <= '0;
            core_r.rounds <= '0;
            core_r.done <= 1'b0;
        end else if (clk_en) begin
            core_r <= core_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // Outputs: read data and set_done straight from flip-flops, activity flags decoded from the state
    //--------------------------------------------------------------------------
    assign reg_rdata = core_r.rdata;
    assign adc_shunt_active = (core_r.st == ST_SHUNT);
    assign adc_bus_active = (core_r.st == ST_BUS);
    assign set_done = core_r.done;

endmodule : pmc_core

// *** hdl/pmc_pkg.sv ***
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pmc_pkg;

    //--------------------------------------------------------------------------
    // Clock and register pointers
    //--------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam logic [7:0] PTR_CONFIG = 8'h00;
    localparam logic [7:0] PTR_SHUNT = 8'h01;
    localparam logic [7:0] PTR_BUS = 8'h02;

    //--------------------------------------------------------------------------
    // Configuration fields and reset values
    //--------------------------------------------------------------------------
    localparam logic [15:0] CFG_RESET_VAL = 16'h4127;
    localparam int CFG_RST_BIT = 15;
    localparam logic [2:0] CFG_RSVD_VAL = 3'h4;
    localparam int AVG_MSB = 11;
    localparam int AVG_LSB = 9;
    localparam int BCT_MSB = 8;
    localparam int BCT_LSB = 6;
    localparam int SCT_MSB = 5;
    localparam int SCT_LSB = 3;
    localparam int MODE_CONT_BIT = 2;
    localparam int MODE_BUS_BIT = 1;
    localparam int MODE_SHUNT_BIT = 0;
    localparam logic [15:0] RESULT_RESET_VAL = 16'h0000;

    //--------------------------------------------------------------------------
    // Conversion times, in ns, and their cycle counts
    //--------------------------------------------------------------------------
    localparam int CONV_TIME_NS [0:7] = '{140000, 204000, 332000, 588000,
                                          1100000, 2116000, 4156000, 8244000};

    // Least time: round up to whole cycles
    function automatic logic [17:0] ns_to_cycles(input int ns);
        ns_to_cycles = 18'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : ns_to_cycles

    localparam logic [17:0] CONV_CYC_DEF [0:7] = '{
        ns_to_cycles(CONV_TIME_NS[0]), ns_to_cycles(CONV_TIME_NS[1]),
        ns_to_cycles(CONV_TIME_NS[2]), ns_to_cycles(CONV_TIME_NS[3]),
        ns_to_cycles(CONV_TIME_NS[4]), ns_to_cycles(CONV_TIME_NS[5]),
        ns_to_cycles(CONV_TIME_NS[6]), ns_to_cycles(CONV_TIME_NS[7])};

    // Averaging code to log2 of the sample count; all counts are powers of two
    function automatic logic [3:0] avg_shift(input logic [2:0] code);
        case (code)
            3'h0: avg_shift = 4'h0;
            3'h1: avg_shift = 4'h2;
            3'h2: avg_shift = 4'h4;
            3'h3: avg_shift = 4'h6;
            3'h4: avg_shift = 4'h7;
            3'h5: avg_shift = 4'h8;
            3'h6: avg_shift = 4'h9;
            default: avg_shift = 4'ha;
        endcase
    endfunction : avg_shift

    typedef enum logic [1:0] {ST_START, ST_SHUNT, ST_BUS, ST_IDLE} pmc_state_e;

endpackage : pmc_pkg

// *** verif/pmc_adc_model.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Converter stand-in: supplies shunt and bus codes
// -----------------------------------------------------------------------------
module pmc_adc_model (
    input wire logic sys_clk,
    input wire logic adc_shunt_active,
    input wire logic adc_bus_active,
    input wire logic [15:0] sh_a,
    input wire logic [15:0] sh_b,
    input wire logic [14:0] bus_a,
    input wire logic [14:0] bus_b,
    output logic [15:0] shunt_drop_value,
    output logic [14:0] supply_rail_value
);
    logic par = 1'b0; // Selects a or b; flips at the end of each bus conversion
    logic bus_q = 1'b0; // Bus activity one clock back
    // Flip after the bus conversion so both channels of a round share a choice;
    // clocked, so the unknown level before reset cannot count as a falling edge
    always @(posedge sys_clk) begin
        bus_q <= adc_bus_active;
        if (bus_q && !adc_bus_active) par <= ~par;
    end
    // Codes are only valid while converting; idle shows the inverse
    always_comb begin
        shunt_drop_value = par ? sh_b : sh_a;
        supply_rail_value = par ? bus_b : bus_a;
        if (!adc_shunt_active) shunt_drop_value = ~shunt_drop_value;
        if (!adc_bus_active) supply_rail_value = ~supply_rail_value;
    end
endmodule : pmc_adc_model

// *** verif/pmc_core_checker.sv ***
`timescale 1ns/1ps
module pmc_core_checker
    import pmc_pkg::*;
#(
    parameter logic [17:0] CONV_CYC [0:7] = CONV_CYC_DEF
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [7:0] reg_ptr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] shunt_drop_value,
    input wire logic [14:0] supply_rail_value,
    input wire logic adc_shunt_active,
    input wire logic adc_bus_active,
    input wire logic set_done
);
    // -------------------------------------------------------------------------
    // Shadow config, shunt run length, abort mark
    // -------------------------------------------------------------------------
    logic [15:0] cfg_r;
    logic [17:0] len_r;
    logic abort_r; // A run cut short by a write has no fixed length
    logic wr_cfg;
    assign wr_cfg = clk_en && reg_wr && reg_ptr == PTR_CONFIG;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cfg_r <= CFG_RESET_VAL;
            len_r <= 18'h0;
            abort_r <= 1'b0;
        end else begin
            if (wr_cfg) cfg_r <= reg_wdata[15] ? CFG_RESET_VAL : {1'b0, CFG_RSVD_VAL, reg_wdata[11:0]};
            if (clk_en) len_r <= adc_shunt_active ? len_r + 18'h1 : 18'h0;
            abort_r <= (adc_shunt_active && abort_r) || wr_cfg;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    bus_top_zero_a: assert property (clk_en && reg_rd && reg_ptr == PTR_BUS |=> !reg_rdata[15])
        else $error("bus result top bit set");
    cfg_readback_a: assert property (clk_en && reg_rd && reg_ptr == PTR_CONFIG |=> reg_rdata == $past(cfg_r))
        else $error("config readback wrong");
    unmapped_zero_a: assert property (clk_en && reg_rd && reg_ptr > PTR_BUS |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!(clk_en && (reg_rd || reg_wr)) |=> $stable(reg_rdata))
        else $error("read data moved without access");
    one_channel_a: assert property (!(adc_shunt_active && adc_bus_active))
        else $error("both conversions at once");
    no_shunt_a: assert property (!cfg_r[MODE_SHUNT_BIT] |=> !adc_shunt_active)
        else $error("shunt runs while deselected");
    no_bus_a: assert property (!cfg_r[MODE_BUS_BIT] |=> !adc_bus_active)
        else $error("bus runs while deselected");
    done_pulse_a: assert property (set_done |=> !set_done)
        else $error("set done longer than one cycle");
    shunt_len_a: assert property ($fell(adc_shunt_active) && !abort_r |-> len_r == CONV_CYC[cfg_r[5:3]])
        else $error("shunt conversion length wrong");
endmodule : pmc_core_checker

bind pmc_core pmc_core_checker #(.CONV_CYC(CONV_CYC)) pmc_core_checker_i (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .shunt_drop_value(shunt_drop_value), .supply_rail_value(supply_rail_value),
    .adc_shunt_active(adc_shunt_active), .adc_bus_active(adc_bus_active), .set_done(set_done));

// *** verif/tb_pmc_core.sv ***
`timescale 1ns/1ps
module tb_pmc_core;
    import pmc_pkg::*;
    // Short conversion times keep the full averaging sweep quick
    localparam logic [17:0] CT [0:7] = '{18'h4, 18'h5, 18'h6, 18'h7, 18'h8, 18'h9, 18'ha, 18'hb};
    localparam int NAVG [0:7] = '{1, 4, 16, 64, 128, 256, 512, 1024};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_ptr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, sh_val, sh_a = 16'h8300, sh_b = 16'h8300;
    logic [14:0] bus_val, bus_a = 15'h7fff, bus_b = 15'h7fff;
    logic sh_act, bus_act, done;
    int n_errors = 0, check_count = 0, cyc = 0, n_sh, c_sh, c_bus;
    // -------------------------------------------------------------------------
    // Clock, design, converter model
    // -------------------------------------------------------------------------
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    pmc_core #(.CONV_CYC(CT)) pmc_core_i (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_ptr(reg_ptr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .shunt_drop_value(sh_val),
        .supply_rail_value(bus_val), .adc_shunt_active(sh_act), .adc_bus_active(bus_act), .set_done(done));
    pmc_adc_model pmc_adc_model_i (.sys_clk(sys_clk), .adc_shunt_active(sh_act), .adc_bus_active(bus_act),
        .sh_a(sh_a), .sh_b(sh_b), .bus_a(bus_a), .bus_b(bus_b), .shunt_drop_value(sh_val),
        .supply_rail_value(bus_val));
    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    task automatic complete_run;
        if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(posedge sys_clk) #1;
        reg_ptr = p;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk) #1;
        reg_wr = 1'b0;
    endtask : wr
    // Read data is registered at the taking edge
    task automatic rd(input logic [7:0] p, input logic [15:0] exp);
        @(posedge sys_clk) #1;
        reg_ptr = p;
        reg_rd = 1'b1;
        @(posedge sys_clk) #1;
        reg_rd = 1'b0;
        cmp(reg_rdata, exp);
    endtask : rd
    // Count shunt starts and active cycles; optionally stop at set_done
    task automatic watch(input int lim, input bit stop);
        bit last;
        last = 1'b0;
        n_sh = 0;
        c_sh = 0;
        c_bus = 0;
        for (int i = 0; i < lim; i++) begin
            n_sh += int'(sh_act === 1'b1 && !last);
            c_sh += int'(sh_act === 1'b1);
            c_bus += int'(bus_act === 1'b1);
            last = (sh_act === 1'b1);
            if (stop && done === 1'b1) break;
            @(posedge sys_clk) #1;
        end
    endtask : watch
    // Cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            complete_run();
        end
    end
    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        rd(PTR_CONFIG, CFG_RESET_VAL);
        rd(PTR_SHUNT, RESULT_RESET_VAL);
        rd(PTR_BUS, RESULT_RESET_VAL);
        watch(100, 1);
        cmp(16'(c_bus), 16'(CT[4]));
        rd(PTR_SHUNT, 16'h8300);
        rd(PTR_BUS, 16'h7fff);
        sh_a = 16'h7fff;
        sh_b = 16'h7fff;
        bus_a = 15'h0001;
        bus_b = 15'h0001;
        wr(PTR_CONFIG, CFG_RESET_VAL);
        watch(100, 1);
        rd(PTR_SHUNT, 16'h7fff);
        rd(PTR_BUS, 16'h0001);
        // Alternating samples: single results differ from the mean
        sh_a = 16'hfff0;
        sh_b = 16'h0008;
        bus_a = 15'h0010;
        bus_b = 15'h0020;
        for (int a = 0; a < 8; a++) begin
            wr(PTR_CONFIG, {4'h0, 3'(a), 9'h003});
            watch(12000, 1);
            cmp(16'(n_sh), 16'(NAVG[a]));
            if (a > 0) begin
                rd(PTR_SHUNT, 16'hfffc);
                rd(PTR_BUS, 16'h0018);
            end
        end
        watch(30, 0);
        cmp(16'(n_sh + c_bus), 16'h0000);
        for (int c = 0; c < 8; c++) begin
            wr(PTR_CONFIG, {7'h00, 3'(c), 3'(7 - c), 3'h3});
            watch(100, 1);
            cmp(16'(c_sh), 16'(CT[7 - c]));
            cmp(16'(c_bus), 16'(CT[c]));
        end
        sh_a = 16'h8001;
        sh_b = 16'h8001;
        bus_a = 15'h0100;
        bus_b = 15'h0100;
        for (int m = 0; m < 8; m++) begin
            wr(PTR_CONFIG, {13'h0000, 3'(m)});
            watch(40, 0);
            cmp(16'(n_sh > 1 ? 2 : n_sh), 16'(m[0] ? (m[2] ? 2 : 1) : 0));
            cmp(16'(c_bus > 0), 16'(m[1]));
        end
        // Result registers are read-only; these writes must not land
        wr(PTR_SHUNT, 16'h1234);
        wr(PTR_BUS, 16'h1234);
        rd(PTR_SHUNT, 16'h8001);
        rd(PTR_BUS, 16'h0100);
        // A read while the clock enable is low is not taken
        clk_en = 1'b0;
        rd(PTR_CONFIG, 16'h0100);
        clk_en = 1'b1;
        rd(8'h03, 16'h0000);
        rd(8'hff, 16'h0000);
        wr(PTR_CONFIG, 16'hffff);
        rd(PTR_SHUNT, RESULT_RESET_VAL);
        rd(PTR_CONFIG, CFG_RESET_VAL);
        complete_run();
    end
endmodule : tb_pmc_core
